// file: sac_pkg.sv
// Purpose: Shared constants and carriers for the converter control block
// Assumes: 10 MHz system clock
// Notes: Timing counts are derived from printed times
package sac_pkg;
  localparam int RES_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_STAGES = 2;
  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_TIME_NS = 600;
  // Longest time rounds down, never below one cycle
  localparam int CONV_CYCLES = (CONV_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : (CONV_TIME_NS / CLK_PERIOD_NS);
  localparam int CNT_W = 4;
  localparam int BIT_CNT_W = 5;
  localparam logic [BIT_CNT_W-1:0] SER_BITS = 5'h10;
  localparam int SER_LINE = 10;
  localparam int BYTE_W = 8;
  localparam logic [RES_W-1:0] RES_RST = 16'h0000;
  localparam logic [RES_W-1:0] MSB_MASK = 16'h8000;

  typedef struct packed {
    logic ser_sel;
    logic ob_fmt;
    logic swap;
    logic pd;
    logic cs_n;
    logic rd_n;
    logic start_n;
  } sac_pins_s;

  typedef enum logic [1:0] {ST_ACQ, ST_CONV, ST_STORE} sac_state_e;
endpackage

// file: sac_adc_ctrl.sv
// Purpose: Conversion sequencing and parallel/serial result port of a 16-bit SAR converter
// Assumes: Result code arrives on sample_code in offset binary; lines 9 and 11 are wired to
//          chain_serial_in and shift_clk by the board when serial mode is used
// Notes: Overview of operation below
//        Control pins pass a two-flop synchroniser and the start edge is found after it,
//        so a start is taken two to three system clocks after the pin falls.
//        The synchroniser is cleared to the idle level of every pin. A cleared value of
//        zero would look like a start edge and an open read frame on the first clock
//        after reset, which would start a false conversion and drive the bus.
//        The queue holds eight results. When it is full, busy stays high until a read
//        frame pops the head, so a result is never overwritten.
//        The shift domain reads the formatted word without a synchroniser. That is safe
//        only because the word is frozen while chip select is low: the host must keep
//        chip select high for at least three system clocks after busy falls.
//        Line 10 in serial mode is a mux and not a flop, so the bit follows the shift
//        clock edge directly. Every other output comes from a register.
//        Reset clears the queue too, so a result that was not read is lost.
// Overview of operation
// - serial_parallel_select high picks the serial port, low the parallel bus.
// - In serial mode all unused outputs stay high impedance.
// - code_format_select high gives offset binary, low inverts MSB for two's complement.
// - byte_order_swap low: line 15 carries MSB, line 0 carries LSB.
// - byte_order_swap high exchanges upper and lower result bytes on the lines.
// - Serial mode: line 9 chain input, line 10 serial output, line 11 shift clock.
// - Serial result goes MSB first, launched on rising shift clock edges.
// - Chain input level reappears on serial output sixteen shift periods later.
// - busy rises at conversion start and falls when the result is ready.
// - Output drivers enabled only while chip select and read strobe are both low.
// - Chip select high blocks the shift clock.
// - Reset holds the device, aborts a conversion and floats the data bus.
// - Power-down high ignores every conversion start request.
// - Falling convert_start_n puts sample-and-hold into hold and starts conversion.
// - Conversion start works whatever the chip select level.
`timescale 1ns/1ps

module sac_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

module sac_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage carries no reset so it can map to RAM
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

module sac_adc_ctrl
  import sac_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic shift_clk,
  input wire logic convert_start_n,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic power_down_in,
  input wire logic serial_parallel_select,
  input wire logic code_format_select,
  input wire logic byte_order_swap,
  input wire logic chain_serial_in,
  input wire logic [RES_W-1:0] sample_code,
  output logic busy,
  output logic sample_hold,
  output logic [RES_W-1:0] parallel_line_out,
  output logic [RES_W-1:0] parallel_line_oe
);
  // Idle level of every control pin; the synchroniser carries the difference from it,
  // so its cleared state reads as idle pins, not as an active start or read frame
  localparam sac_pins_s PIN_IDLE = '{ser_sel: 1'h0, ob_fmt: 1'h0, swap: 1'h0, pd: 1'h0,
                                     cs_n: 1'h1, rd_n: 1'h1, start_n: 1'h1};
  sac_pins_s pins_raw;
  sac_pins_s pins;
  logic [$bits(sac_pins_s)-1:0] pins_flip;
  sac_state_e state;
  sac_state_e next_state;
  logic [CNT_W-1:0] conv_cnt;
  logic [CNT_W-1:0] next_conv_cnt;
  logic start_d;
  logic [RES_W-1:0] captured;
  logic [RES_W-1:0] next_captured;
  logic next_busy;
  logic next_hold;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [RES_W-1:0] head_word;
  logic read_seen;
  logic next_read_seen;
  logic cs_d;
  logic [RES_W-1:0] fmt_word;
  logic [RES_W-1:0] next_fmt_word;
  logic [RES_W-1:0] par_q;
  logic [RES_W-1:0] next_par_q;
  logic [RES_W-1:0] next_oe;
  logic read_act;
  logic start_fall;
  logic [BIT_CNT_W-1:0] bit_cnt;
  logic [RES_W-1:0] chain_sr;
  logic [RES_W-1:0] shifted;
  logic serial_bit;

  assign pins_raw = '{ser_sel: serial_parallel_select, ob_fmt: code_format_select, swap: byte_order_swap,
                      pd: power_down_in, cs_n: chip_select_n, rd_n: read_n, start_n: convert_start_n};

  sac_sync #(.W($bits(sac_pins_s))) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(pins_raw ^ PIN_IDLE),
    .q(pins_flip)
  );

  // Back to true pin levels; after reset this equals PIN_IDLE, so no false edge follows
  assign pins = pins_flip ^ PIN_IDLE;

  // Start is edge driven and independent of chip select
  assign start_fall = start_d && !pins.start_n && !pins.pd;
  assign fifo_in_valid = (state == ST_STORE);
  assign read_act = !pins.cs_n && !pins.rd_n;
  // Result leaves the queue once the read frame that showed it has ended
  assign fifo_pop = cs_d == 1'b0 && pins.cs_n && read_seen;

  // Conversion sequencer. Starts that arrive while busy is high are dropped on purpose:
  // the sampled value is already held, and a second hold would corrupt the result.
  // The result is taken from sample_code on the last conversion clock only.
  always_comb begin
    next_state = state;
    next_conv_cnt = conv_cnt;
    next_captured = captured;
    next_busy = busy;
    next_hold = sample_hold;
    unique case (state)
      ST_ACQ: begin
        if (start_fall) begin
          next_state = ST_CONV;
          next_conv_cnt = '0;
          next_busy = 1'b1;
          next_hold = 1'b1;
        end
      end
      ST_CONV: begin
        next_conv_cnt = conv_cnt + 1'b1;
        if (conv_cnt == CNT_W'(CONV_CYCLES - 1)) begin
          next_state = ST_STORE;
          next_captured = sample_code;
          next_hold = 1'b0;
        end
      end
      ST_STORE: begin
        // A full queue stretches busy until the host drains a word
        if (fifo_in_ready) begin
          next_state = ST_ACQ;
          next_busy = 1'b0;
        end
      end
    endcase
  end

  // Asynchronous reset aborts any conversion in flight
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_ACQ;
      conv_cnt <= '0;
      captured <= RES_RST;
      busy <= 1'b0;
      sample_hold <= 1'b0;
      start_d <= 1'b1;
    end else begin
      state <= next_state;
      conv_cnt <= next_conv_cnt;
      captured <= next_captured;
      busy <= next_busy;
      sample_hold <= next_hold;
      start_d <= pins.start_n;
    end
  end

  // Results queue in arrival order; the head is what the next read frame shows.
  // A frame pops the head only if it really read data, so an empty frame loses nothing.
  sac_fifo #(.WIDTH(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(captured),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(head_word)
  );

  always_comb begin
    next_read_seen = read_seen;
    if (fifo_pop) begin
      next_read_seen = 1'b0;
    end else if (read_act && fifo_out_valid) begin
      next_read_seen = 1'b1;
    end
    next_fmt_word = fmt_word;
    // Word is frozen while selected so the shift domain sees a steady value
    if (pins.cs_n && !fifo_pop) begin
      next_fmt_word = fifo_out_valid ? head_word : RES_RST;
      if (!pins.ob_fmt) begin
        next_fmt_word = next_fmt_word ^ MSB_MASK;
      end
    end
    next_par_q = pins.swap ? {fmt_word[BYTE_W-1:0], fmt_word[RES_W-1:BYTE_W]} : fmt_word;
    // Drivers follow the synchronised strobes, so they open and close about three
    // clocks after the pins move; the host must allow for that access time.
    next_oe = '0;
    if (read_act) begin
      if (pins.ser_sel) begin
        next_oe[SER_LINE] = 1'b1;
      end else begin
        next_oe = '1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      read_seen <= 1'b0;
      cs_d <= 1'b1;
      fmt_word <= RES_RST;
      par_q <= RES_RST;
      parallel_line_oe <= '0;
    end else begin
      read_seen <= next_read_seen;
      cs_d <= pins.cs_n;
      fmt_word <= next_fmt_word;
      par_q <= next_par_q;
      parallel_line_oe <= next_oe;
    end
  end

  // Shift domain: chip select high holds it cleared, so stray edges do nothing
  // The count stops at sixteen; from then on the chain register feeds line 10, so
  // a longer frame passes the results of parts further down the chain.
  // Chip select is used raw here: its rising edge clears at once, with no clock.
  always_ff @(posedge shift_clk or posedge chip_select_n or posedge sys_rst) begin
    if (sys_rst || chip_select_n) begin
      bit_cnt <= '0;
      chain_sr <= RES_RST;
    end else begin
      if (bit_cnt != SER_BITS) begin
        bit_cnt <= bit_cnt + 1'b1;
      end
      chain_sr <= {chain_sr[RES_W-2:0], chain_serial_in};
    end
  end

  // Count zero presents the MSB before the first edge
  assign shifted = fmt_word << bit_cnt[CNT_W-1:0];
  assign serial_bit = (bit_cnt == SER_BITS) ? chain_sr[RES_W-1] : shifted[RES_W-1];

  // Line 10 carries the serial bit in serial mode; a mux, as the bit must move without a local edge
  always_comb begin
    parallel_line_out = par_q;
    if (pins.ser_sel) begin
      parallel_line_out[SER_LINE] = serial_bit;
    end
  end
endmodule

// file: sac_adc_ctrl_assertions.sv
// Purpose: Port checks for sac_adc_ctrl
// Assumes: Pins pass a 2-flop sync and one output register
// Notes: Shift-clock domain is judged by the bench
`timescale 1ns/1ps
module sac_adc_ctrl_assertions
  import sac_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic shift_clk,
  input wire logic convert_start_n,
  input wire logic chip_select_n,
  input wire logic read_n,
  input wire logic power_down_in,
  input wire logic serial_parallel_select,
  input wire logic code_format_select,
  input wire logic byte_order_swap,
  input wire logic chain_serial_in,
  input wire logic [RES_W-1:0] sample_code,
  input wire logic busy,
  input wire logic sample_hold,
  input wire logic [RES_W-1:0] parallel_line_out,
  input wire logic [RES_W-1:0] parallel_line_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_hold;
    sample_hold [*6] ##1 !sample_hold;
  endsequence
  a_conv_time: assert property ($rose(busy) |-> s_hold ##1 !busy) else $error("conv time");
  a_hold_busy: assert property (sample_hold |-> busy) else $error("hold without busy");
  a_start_busy: assert property ($fell(convert_start_n) && !busy && !power_down_in |-> ##[2:5] $rose(busy))
    else $error("start lost");
  a_pd_block: assert property ($rose(busy) |-> !($past(power_down_in, 2) && $past(power_down_in, 3)
    && $past(power_down_in, 4))) else $error("start in power down");
  a_oe_gate: assert property (|parallel_line_oe |-> $past(!chip_select_n && !read_n, 3))
    else $error("drive without select");
  a_ser_lines: assert property (|(parallel_line_oe & 16'hFBFF) |-> !$past(serial_parallel_select, 3))
    else $error("unused line driven");
  a_par_all: assert property (|parallel_line_oe && !$past(serial_parallel_select, 3) |-> &parallel_line_oe)
    else $error("partial bus");
  a_word_held: assert property (&parallel_line_oe && $past(&parallel_line_oe) |-> $stable(parallel_line_out))
    else $error("word moved");
endmodule
bind sac_adc_ctrl sac_adc_ctrl_assertions i_chk (.*);

// file: sac_host_model.sv
// Purpose: Host side of the serial read
// Assumes: 125 ns shift period, chain input held high
// Notes: Clock stands still between frames
`timescale 1ns/1ps
module sac_host_model (
  input wire logic go,
  input wire logic sdo,
  output logic sclk,
  output logic sdi,
  output logic [31:0] rx
);
  initial begin
    sclk = 0;
    sdi = 1;
    rx = '0;
  end
  // Bit taken late in each low phase, where it is settled
  always @(go) begin
    for (int i = 0; i < 32; i++) begin
      #60;
      rx = {rx[30:0], sdo};
      #2.5 sclk = 1;
      #62.5 sclk = 0;
    end
  end
endmodule

// file: tb_top.sv
// Purpose: Self-checking bench for sac_adc_ctrl
// Assumes: Inputs other than shift_clk change 1 ns after the rising clock edge
// Notes: Queue never filled, so busy length is fixed
`timescale 1ns/1ps
module tb_top import sac_pkg::*; ;
  logic clk = 0, sys_rst = 1, shift_clk, convert_start_n = 1, chip_select_n = 1, read_n = 1;
  logic power_down_in = 0, serial_parallel_select = 0, code_format_select = 1, byte_order_swap = 0;
  logic chain_serial_in, busy, sample_hold, go = 0;
  logic [15:0] sample_code = '0, parallel_line_out, parallel_line_oe, w;
  logic [31:0] rx;
  int failures = 0, cmp_count = 0;
  wire sdo = parallel_line_oe[10] ? parallel_line_out[10] : 1'bz;
  sac_adc_ctrl i_dut (.*);
  sac_host_model i_host (.go(go), .sdo(sdo), .sclk(shift_clk), .sdi(chain_serial_in), .rx(rx));
  always #50 clk = ~clk;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("Error %0t: got %h exp %h", $time, got, exp);
      failures++;
    end
  endtask
  function automatic logic [15:0] fmt(input logic [15:0] c, input logic f, input logic s);
    logic [15:0] x;
    x = f ? c : c ^ MSB_MASK;
    return s ? {x[7:0], x[15:8]} : x;
  endfunction
  task automatic start;
    convert_start_n = 0;
    tick(2);
    convert_start_n = 1;
  endtask
  task automatic convert(input logic [15:0] c);
    int n;
    n = 0;
    sample_code = c;
    start();
    while (busy !== 1'b1 && n < 9) begin
      tick(1);
      n++;
    end
    chk(busy, 1);
    while (busy !== 1'b0 && n < 30) begin
      tick(1);
      n++;
    end
    chk(busy, 0);
    tick(8);
  endtask
  task automatic pread(input logic [15:0] e);
    chip_select_n = 0;
    read_n = 0;
    tick(5);
    chk(parallel_line_oe, 16'hFFFF);
    chk(parallel_line_out, e);
    chip_select_n = 1;
    read_n = 1;
    tick(6);
    chk(parallel_line_oe, 16'h0000);
  endtask
  task automatic end_of_test;
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    tick(12);
    sys_rst = 0;
    chk(parallel_line_oe, 16'h0000);
    tick(4);
    for (int f = 0; f < 4; f++) begin
      code_format_select = f[0];
      byte_order_swap = f[1];
      w = {12'hA5C, f[3:0]};
      convert(w);
      pread(fmt(w, f[0], f[1]));
    end
    // Result already read out before power-down
    power_down_in = 1;
    tick(4);
    start();
    tick(6);
    chk(busy, 0);
    power_down_in = 0;
    tick(4);
    start();
    tick(3);
    chk(busy, 1);
    sys_rst = 1;
    tick(1);
    chk(busy, 0);
    chk(parallel_line_oe, 16'h0000);
    sys_rst = 0;
    serial_parallel_select = 1;
    code_format_select = 0;
    byte_order_swap = 0;
    tick(4);
    convert(16'h9E71);
    go = ~go;
    tick(45);
    chip_select_n = 0;
    read_n = 0;
    tick(5);
    chk(parallel_line_oe, 16'h0400);
    go = ~go;
    tick(45);
    chk(rx[31:16], 16'h1E71);
    chk(rx[14:0], 15'h7FFF);
    chip_select_n = 1;
    read_n = 1;
    tick(6);
    end_of_test();
  end
  initial begin
    #100000;
    failures++;
    end_of_test();
  end
endmodule
